// >>> dv/ump_far_port.sv
// Far-side serial port model: frame sender and frame monitor
module ump_far_port
	import ump_pkg::*;
#(
	parameter int BIT = 32
) (
	input  wire logic sys_clk,
	input  wire logic nine_mode,
	input  wire logic tx_pin,
	output logic      rx_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	ump_word_t got_q[$];
	logic      got_stop;
	initial rx_pin = 1'b1;
	// Ninth bit marks address frames
	// Mode comes in as an argument: the port may lag a same-step update
	task automatic send(input ump_word_t w, input logic stop,
		input logic nine);
		logic [10:0] fr;
		int          n;
		fr = {stop, w.ninth, w.data, 1'b0};
		n = nine ? 11 : 10;
		if (!nine)
			fr[9] = stop;
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			rx_pin <= fr[i];
			repeat (BIT - 1) @(posedge sys_clk);
		end
		@(posedge sys_clk);
		rx_pin <= 1'b1;
		repeat (BIT) @(posedge sys_clk);
	endtask
	// Mid-bit sampling; 8-bit frames keep the stop bit as ninth
	always begin
		ump_word_t w;
		@(negedge tx_pin);
		repeat (BIT / 2) @(posedge sys_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge sys_clk);
			if (i < 8)
				w.data[i] = tx_pin;
			else
				w.ninth = tx_pin;
		end
		got_stop = w.ninth;
		if (nine_mode) begin
			repeat (BIT) @(posedge sys_clk);
			got_stop = tx_pin;
		end
		got_q.push_back(w);
	end
endmodule

// >>> dv/ump_serial_port_tb_top.sv
// Self-checking bench for the multiprocessor serial port
module ump_serial_port_tb_top;
	import ump_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic       sys_clk = 1'b0;
	logic       arst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic       sfr_wr = 1'b0;
	logic       sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic       tx_ready;
	logic       tx_ovf = 1'b0;
	logic       rx_pin;
	logic       tx_pin;
	logic       irq_req;
	logic       nine_mode = 1'b0;
	logic [7:0] v;
	logic [47:0] c;
	int         num_errors = 0;
	int         total_checks = 0;
	int         cyc = 0;
	// ctrl, byte, ninth, stop, expected ctrl, expected data
	logic [47:0] rxc [8] = '{48'h00_11_00_01_40_00, 48'h10_5A_00_01_55_5A,
		48'h11_77_00_01_51_5A, 48'h30_66_00_00_70_5A,
		48'h10_66_00_00_51_66, 48'hB0_23_00_01_F0_66,
		48'hB0_42_01_01_F5_42, 48'h90_0F_00_01_D1_0F};
	// ctrl, byte, expected ctrl after sending
	logic [23:0] txc [3] = '{24'h00_A5_42, 24'h88_C3_CA, 24'h80_96_C2};
	always #25 sys_clk = ~sys_clk;
	ump_serial_port u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.tx_ready(tx_ready), .tx_ovf(tx_ovf), .tmr_tick(1'b1),
		.tmr_reload(8'hF0), .rx_pin(rx_pin), .tx_pin(tx_pin),
		.irq_req(irq_req));
	ump_far_port #(.BIT(32)) u_far (.sys_clk(sys_clk),
		.nine_mode(nine_mode), .tx_pin(tx_pin), .rx_pin(rx_pin));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (a == UMP_DATA_ADDR && tx_ready !== 1'b1 && n < 2000) begin
			@(posedge sys_clk);
			n++;
		end
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge sys_clk);
		sfr_rd <= 1'b0;
		@(posedge sys_clk);
		d = sfr_rdata;
	endtask
	// Timer overflow every 16 cycles, bit time 32 cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		tx_ovf <= (cyc % 16 == 15);
		if (cyc == 30000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		chk1(tx_ready, 1'b1);
		chk1(irq_req, 1'b0);
		chk1(tx_pin, 1'b1);
		rd(UMP_CTRL_ADDR, v);
		chk8(v, UMP_CTRL_RESET);
		rd(UMP_DATA_ADDR, v);
		chk8(v, UMP_DATA_RESET);
		wr(8'h9A, 8'hFF);
		wr(UMP_CTRL_ADDR, 8'h00);
		rd(UMP_CTRL_ADDR, v);
		chk8(v, 8'h40);
		$display("test registers done");
		for (int k = 0; k < 8; k++) begin
			c = rxc[k];
			wr(UMP_CTRL_ADDR, c[47:40]);
			nine_mode <= c[47];
			u_far.send(ump_word_t'({c[24], c[39:32]}), c[16],
				c[47]);
			rd(UMP_CTRL_ADDR, v);
			chk8(v, c[15:8]);
			rd(UMP_DATA_ADDR, v);
			chk8(v, c[7:0]);
			chk1(irq_req, c[8]);
		end
		$display("test receive done");
		for (int k = 0; k < 3; k++) begin
			wr(UMP_CTRL_ADDR, txc[k][23:16]);
			nine_mode <= txc[k][23];
			wr(UMP_DATA_ADDR, txc[k][15:8]);
			wr(UMP_DATA_ADDR, ~txc[k][15:8]);
			for (int n = 0; n < 2000 && u_far.got_q.size() < 2; n++)
				@(posedge sys_clk);
			chk8(8'(u_far.got_q.size()), 8'h02);
			for (int j = 0; j < 2; j++) begin
				v = j ? ~txc[k][15:8] : txc[k][15:8];
				if (u_far.got_q.size() > 0) begin
					chk8(u_far.got_q[0].data, v);
					chk1(u_far.got_q[0].ninth,
						~txc[k][23] | txc[k][19]);
					void'(u_far.got_q.pop_front());
				end
			end
			chk1(u_far.got_stop, 1'b1);
			repeat (100) @(posedge sys_clk);
			rd(UMP_CTRL_ADDR, v);
			chk8(v, txc[k][7:0]);
			chk1(irq_req, 1'b1);
		end
		$display("test transmit done");
		tally_and_finish();
	end
endmodule

// >>> rtl/ump_pkg.sv
// Constants and types for the multiprocessor serial port
package ump_pkg;
	// Register addresses and reset values
	localparam logic [7:0] UMP_CTRL_ADDR  = 8'h98;
	localparam logic [7:0] UMP_DATA_ADDR  = 8'h99;
	localparam logic [7:0] UMP_CTRL_RESET = 8'h40;
	localparam logic [7:0] UMP_DATA_RESET = 8'h00;
	// Control register field positions
	localparam int UMP_B_MODE = 7;
	localparam int UMP_B_FILL = 6;
	localparam int UMP_B_MCE  = 5;
	localparam int UMP_B_REN  = 4;
	localparam int UMP_B_TB8  = 3;
	localparam int UMP_B_RB8  = 2;
	localparam int UMP_B_TI   = 1;
	localparam int UMP_B_RI   = 0;
	// Frame lengths, start to stop inclusive; data bit count and receive timer top
	localparam logic [3:0] UMP_LEN8 = 4'hA;
	localparam logic [3:0] UMP_LEN9 = 4'hB;
	localparam logic [3:0] UMP_DBITS = 4'h8;
	localparam logic [7:0] UMP_TMR_TOP = 8'hFF;

	typedef struct packed {
		logic       ninth;
		logic [7:0] data;
	} ump_word_t;

	typedef enum logic [1:0] {
		UMP_RX_IDLE,
		UMP_RX_START,
		UMP_RX_DATA,
		UMP_RX_STOP
	} ump_rx_st_t;
endpackage

// >>> rtl/ump_serial_port.sv
// Serial port with 8/9-bit frames and address filtering
module ump_serial_port
	import ump_pkg::*;
#(
	parameter int BUF_DEPTH = 2
) (
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	output logic            tx_ready,
	input  wire logic       tx_ovf,
	input  wire logic       tmr_tick,
	input  wire logic [7:0] tmr_reload,
	input  wire logic       rx_pin,
	output logic            tx_pin,
	output logic            irq_req
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic [7:0] rx_latch;
	logic [7:0] next_rx_latch;
	logic [7:0] next_rdata;
	logic       ctrl_wr;
	logic       data_wr;
	logic       mode9;
	logic       set_ti;
	logic       rx_load;
	logic       rx_ninth;

	assign ctrl_wr = sfr_wr && (sfr_addr == UMP_CTRL_ADDR);
	assign data_wr = sfr_wr && (sfr_addr == UMP_DATA_ADDR);
	assign mode9   = ctrl[UMP_B_MODE];
	assign irq_req = ctrl[UMP_B_TI] | ctrl[UMP_B_RI];

	// Transmit buffer between the data register and the shifter
	localparam int PW = $clog2(BUF_DEPTH);
	ump_word_t          buf_mem [BUF_DEPTH];
	ump_word_t          next_buf_mem [BUF_DEPTH];
	logic [PW-1:0]      buf_wp;
	logic [PW-1:0]      next_buf_wp;
	logic [PW-1:0]      buf_rp;
	logic [PW-1:0]      next_buf_rp;
	logic [PW:0]        buf_cnt;
	logic [PW:0]        next_buf_cnt;
	logic               buf_valid;
	logic               buf_pop;
	logic               buf_push;

	assign tx_ready  = (buf_cnt != (PW+1)'(BUF_DEPTH));
	assign buf_valid = (buf_cnt != '0);
	assign buf_push  = data_wr && tx_ready;

	always_comb begin
		next_buf_mem = buf_mem;
		next_buf_wp  = buf_wp;
		next_buf_rp  = buf_rp;
		next_buf_cnt = buf_cnt;
		if (buf_push) begin
			next_buf_mem[buf_wp] = '{ninth: ctrl[UMP_B_TB8],
				data: sfr_wdata};
			next_buf_wp = (buf_wp == PW'(BUF_DEPTH - 1)) ? '0 :
				PW'(buf_wp + 1'b1);
		end
		if (buf_pop) begin
			next_buf_rp = (buf_rp == PW'(BUF_DEPTH - 1)) ? '0 :
				PW'(buf_rp + 1'b1);
		end
		if (buf_push && !buf_pop) begin
			next_buf_cnt = (PW+1)'(buf_cnt + 1'b1);
		end else if (buf_pop && !buf_push) begin
			next_buf_cnt = (PW+1)'(buf_cnt - 1'b1);
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			buf_mem <= '{default: '0};
			buf_wp  <= '0;
			buf_rp  <= '0;
			buf_cnt <= '0;
		end else begin
			buf_mem <= next_buf_mem;
			buf_wp  <= next_buf_wp;
			buf_rp  <= next_buf_rp;
			buf_cnt <= next_buf_cnt;
		end
	end

	// Transmitter, bit time is two overflows of the baud timer
	logic        tx_ph;
	logic        next_tx_ph;
	logic        tx_busy;
	logic        next_tx_busy;
	logic [10:0] tx_sh;
	logic [10:0] next_tx_sh;
	logic [3:0]  tx_cnt;
	logic [3:0]  next_tx_cnt;
	logic [3:0]  tx_last;
	logic        next_tx_pin;
	logic        tx_tick;
	ump_word_t   tx_word;

	assign tx_word = buf_mem[buf_rp];
	assign tx_tick = tx_ovf && tx_ph;
	assign tx_last = mode9 ? UMP_LEN9 - 4'h1 : UMP_LEN8 - 4'h1;
	assign buf_pop = !tx_busy && buf_valid && tx_tick;

	always_comb begin
		next_tx_ph   = tx_ovf ? !tx_ph : tx_ph;
		next_tx_busy = tx_busy;
		next_tx_sh   = tx_sh;
		next_tx_cnt  = tx_cnt;
		next_tx_pin  = tx_pin;
		set_ti       = 1'b0;
		if (buf_pop) begin
			next_tx_busy = 1'b1;
			next_tx_cnt  = '0;
			next_tx_pin  = 1'b0;
			// Stop, ninth or second stop, data LSB first, start
			next_tx_sh = {1'b1,
				mode9 ? tx_word.ninth : 1'b1,
				tx_word.data, 1'b0};
		end else if (tx_busy && tx_tick) begin
			if (tx_cnt == tx_last) begin
				next_tx_busy = 1'b0;
				next_tx_pin  = 1'b1;
			end else begin
				next_tx_sh  = {1'b1, tx_sh[10:1]};
				next_tx_cnt = tx_cnt + 4'h1;
				next_tx_pin = tx_sh[1];
				set_ti = (tx_cnt + 4'h1 == tx_last);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_ph   <= 1'b0;
			tx_busy <= 1'b0;
			tx_sh   <= '1;
			tx_cnt  <= '0;
			tx_pin  <= 1'b1;
		end else begin
			tx_ph   <= next_tx_ph;
			tx_busy <= next_tx_busy;
			tx_sh   <= next_tx_sh;
			tx_cnt  <= next_tx_cnt;
			tx_pin  <= next_tx_pin;
		end
	end

	// Receive pin synchroniser and edge history
	logic rx_s1;
	logic rx_s2;
	logic rx_prev;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_s1   <= 1'b1;
			rx_s2   <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			rx_s1   <= rx_pin;
			rx_s2   <= rx_s1;
			rx_prev <= rx_s2;
		end
	end

	// Receiver with its own copy of the baud timer
	ump_rx_st_t rx_st;
	ump_rx_st_t next_rx_st;
	logic [7:0] rx_tmr;
	logic [7:0] next_rx_tmr;
	logic       rx_ph;
	logic       next_rx_ph;
	logic [3:0] rx_n;
	logic [3:0] next_rx_n;
	logic [7:0] rx_sh;
	logic [7:0] next_rx_sh;
	logic       rx_b9;
	logic       next_rx_b9;
	logic       rx_ovf;
	logic       rx_smp;
	logic       rx_fall;
	logic       rx_pass;

	assign rx_ovf  = tmr_tick && (rx_tmr == UMP_TMR_TOP);
	assign rx_smp  = rx_ovf && rx_ph;
	assign rx_fall = rx_prev && !rx_s2;
	assign rx_ninth = mode9 ? rx_b9 : rx_s2;
	// Address frames pass; 8-bit mode checks stop level
	assign rx_pass = !ctrl[UMP_B_MCE] || rx_ninth;
	assign rx_load = (rx_st == UMP_RX_STOP) && rx_smp &&
		!ctrl[UMP_B_RI] && rx_pass;

	always_comb begin
		next_rx_st  = rx_st;
		next_rx_n   = rx_n;
		next_rx_sh  = rx_sh;
		next_rx_b9  = rx_b9;
		next_rx_ph  = rx_ovf ? !rx_ph : rx_ph;
		next_rx_tmr = rx_tmr;
		if (rx_ovf) begin
			next_rx_tmr = tmr_reload;
		end else if (tmr_tick) begin
			next_rx_tmr = rx_tmr + 8'h01;
		end
		case (rx_st)
			UMP_RX_IDLE: begin
				if (ctrl[UMP_B_REN] && rx_fall) begin
					next_rx_st  = UMP_RX_START;
					next_rx_tmr = tmr_reload;
					next_rx_ph  = 1'b1;
				end
			end
			UMP_RX_START: begin
				if (rx_smp) begin
					next_rx_st = rx_s2 ? UMP_RX_IDLE : UMP_RX_DATA;
					next_rx_n  = '0;
				end
			end
			UMP_RX_DATA: begin
				if (rx_smp) begin
					next_rx_n = rx_n + 4'h1;
					if (rx_n < UMP_DBITS) begin
						next_rx_sh = {rx_s2, rx_sh[7:1]};
					end else begin
						next_rx_b9 = rx_s2;
					end
					if (rx_n == (mode9 ? UMP_DBITS :
						UMP_DBITS - 4'h1)) begin
						next_rx_st = UMP_RX_STOP;
					end
				end
			end
			UMP_RX_STOP: begin
				if (rx_smp) begin
					next_rx_st = UMP_RX_IDLE;
				end
			end
			default: begin
				next_rx_st = UMP_RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_st  <= UMP_RX_IDLE;
			rx_tmr <= '0;
			rx_ph  <= 1'b0;
			rx_n   <= '0;
			rx_sh  <= '0;
			rx_b9  <= 1'b0;
		end else begin
			rx_st  <= next_rx_st;
			rx_tmr <= next_rx_tmr;
			rx_ph  <= next_rx_ph;
			rx_n   <= next_rx_n;
			rx_sh  <= next_rx_sh;
			rx_b9  <= next_rx_b9;
		end
	end

	// Control, receive latch and read data
	always_comb begin
		next_ctrl     = ctrl;
		next_rx_latch = rx_latch;
		next_rdata    = sfr_rdata;
		if (ctrl_wr) begin
			next_ctrl = sfr_wdata;
		end
		next_ctrl[UMP_B_FILL] = 1'b1;
		if (set_ti) begin
			next_ctrl[UMP_B_TI] = 1'b1;
		end
		if (rx_load) begin
			next_ctrl[UMP_B_RI]  = 1'b1;
			next_ctrl[UMP_B_RB8] = rx_ninth;
			next_rx_latch        = rx_sh;
		end
		if (sfr_rd && sfr_addr == UMP_CTRL_ADDR) begin
			next_rdata = ctrl;
		end else if (sfr_rd && sfr_addr == UMP_DATA_ADDR) begin
			next_rdata = rx_latch;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl      <= UMP_CTRL_RESET;
			rx_latch  <= UMP_DATA_RESET;
			sfr_rdata <= '0;
		end else begin
			ctrl      <= next_ctrl;
			rx_latch  <= next_rx_latch;
			sfr_rdata <= next_rdata;
		end
	end

	// Checks
	ctrl_fill_a: assert property (
		sfr_rd && sfr_addr == UMP_CTRL_ADDR |=> sfr_rdata[6])
		else $error("unused control bit read as zero");
	ri_hold_a: assert property (
		ctrl[UMP_B_RI] && !ctrl_wr |=> ctrl[UMP_B_RI])
		else $error("receive flag cleared without write");
	ti_hold_a: assert property (
		ctrl[UMP_B_TI] && !ctrl_wr |=> ctrl[UMP_B_TI])
		else $error("transmit flag cleared without write");
	rx_gate_a: assert property (
		rx_st == UMP_RX_IDLE && !ctrl[UMP_B_REN]
		|=> rx_st == UMP_RX_IDLE)
		else $error("reception began while disabled");
	rx_overrun_a: assert property (
		ctrl[UMP_B_RI] |=> $stable(rx_latch))
		else $error("latch loaded over pending byte");
	addr_filter_a: assert property (
		rx_st == UMP_RX_STOP && rx_smp && mode9 && ctrl[UMP_B_MCE]
		&& !rx_b9 && !ctrl_wr
		|=> $stable(rx_latch) && $stable(ctrl[UMP_B_RI])
		&& $stable(ctrl[UMP_B_RB8]))
		else $error("data frame passed address filter");
	stop_filter_a: assert property (
		rx_st == UMP_RX_STOP && rx_smp && !mode9 && ctrl[UMP_B_MCE]
		&& !rx_s2 && !ctrl_wr
		|=> $stable(rx_latch) && $stable(ctrl[UMP_B_RI])
		&& $stable(ctrl[UMP_B_RB8]))
		else $error("bad stop passed filter");
	ti_timing_a: assert property (
		set_ti |=> tx_pin && tx_cnt == tx_last && ctrl[UMP_B_TI])
		else $error("transmit flag not at stop start");
	tx_start_a: assert property (
		buf_pop |=> !tx_pin && tx_busy && tx_cnt == 4'h0)
		else $error("start bit not driven");
	rb8_load_a: assert property (
		rx_load |=> ctrl[UMP_B_RB8] == $past(rx_ninth)
		&& rx_latch == $past(rx_sh))
		else $error("ninth bit or latch not captured");
endmodule
